// ### core/lcd_ctrl.sv
// LED current-step controller: enable, pulse counting, sleep, timeout,
// thermal trip. Inputs are driven by the host at all times; the thermal
// comparator input comes with its own hysteresis.
`timescale 1ns/1ps
`include "lcd_map.svh"
module lcd_ctrl #(
  parameter int POR_CYC = `LCD_POR_CYC,
  parameter int TMO_CYC = `LCD_TMO_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_EN,
  input wire logic I_STEP,
  input wire logic I_HOT,
  output logic [`LCD_CODE_W-1:0] O_CODE,
  output logic O_DRIVE,
  output logic O_SETTLED,
  output logic O_SLEEP,
  output logic O_TIMEOUT,
  output logic O_READY
);
  localparam int SLEEP_CYC = `LCD_SLEEP_CYC;
  localparam int SETTLE_CYC = `LCD_SETTLE_CYC;
  typedef struct packed {
    lcd_pkg::lcd_state_t st;
    logic [`LCD_CODE_W-1:0] code;
    logic [31:0] por_cnt;
    logic [31:0] low_cnt;
    logic [31:0] tmo_cnt;
    logic [31:0] set_cnt;
    logic tmo;
    logic drive;
    logic settled;
  } lcd_ctrl_t;
  lcd_ctrl_t r;
  lcd_ctrl_t next_r;
  logic en_q;
  logic en_rise;
  logic step_q;
  logic step_rise;
  logic hot_q;
  logic hot_rise;

  lcd_sync u_en (
    .i_clk(I_REF_CLK),
    .i_rst(I_RESET),
    .i_d(I_EN),
    .o_q(en_q),
    .o_rise(en_rise)
  );
  lcd_sync u_step (
    .i_clk(I_REF_CLK),
    .i_rst(I_RESET),
    .i_d(I_STEP),
    .o_q(step_q),
    .o_rise(step_rise)
  );
  lcd_sync u_hot (
    .i_clk(I_REF_CLK),
    .i_rst(I_RESET),
    .i_d(I_HOT),
    .o_q(hot_q),
    .o_rise(hot_rise)
  );

  function automatic logic lcd_live(input lcd_pkg::lcd_state_t s);
    lcd_live = (s == lcd_pkg::LCD_ON) || (s == lcd_pkg::LCD_SLEEP);
  endfunction : lcd_live

  always_comb begin
    next_r = r;
    next_r.drive = 1'b0;
    case (r.st)
      lcd_pkg::LCD_POR: begin
        // Steps ignored until the power-on interval ends
        if (r.por_cnt >= 32'(POR_CYC - 1)) begin
          next_r.st = lcd_pkg::LCD_OFF;
        end else begin
          next_r.por_cnt = r.por_cnt + 32'h1;
        end
      end
      lcd_pkg::LCD_OFF: begin
        next_r.code = '0;
        next_r.tmo = 1'b0;
        next_r.tmo_cnt = '0;
        next_r.low_cnt = '0;
        if (en_q) begin
          next_r.st = lcd_pkg::LCD_ON;
        end
      end
      lcd_pkg::LCD_ON, lcd_pkg::LCD_SLEEP: begin
        if (step_rise && r.code != `LCD_CODE_MAX) begin
          next_r.code = r.code + 5'h1;
          next_r.set_cnt = '0;
        end else if (r.set_cnt < 32'(SETTLE_CYC)) begin
          next_r.set_cnt = r.set_cnt + 32'h1;
        end
        if (step_q) begin
          next_r.low_cnt = '0;
        end else if (r.low_cnt < 32'(SLEEP_CYC)) begin
          next_r.low_cnt = r.low_cnt + 32'h1;
        end
        if (r.code > `LCD_CODE_HI && r.st == lcd_pkg::LCD_ON) begin
          if (r.tmo_cnt >= 32'(TMO_CYC - 1)) begin
            next_r.tmo = 1'b1;
          end else begin
            next_r.tmo_cnt = r.tmo_cnt + 32'h1;
          end
        end
        if (!en_q) begin
          next_r.st = lcd_pkg::LCD_OFF;
        end else if (next_r.tmo || hot_q ||
            next_r.low_cnt >= 32'(SLEEP_CYC)) begin
          next_r.st = lcd_pkg::LCD_SLEEP;
        end else if (!r.tmo) begin
          next_r.st = lcd_pkg::LCD_ON;
          next_r.drive = 1'b1;
        end
      end
      default: begin
        next_r.st = lcd_pkg::LCD_POR;
      end
    endcase
    next_r.settled = next_r.drive && next_r.set_cnt >= 32'(SETTLE_CYC);
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign O_CODE = r.code;
  assign O_DRIVE = r.drive;
  assign O_SETTLED = r.settled;
  assign O_SLEEP = (r.st == lcd_pkg::LCD_SLEEP);
  assign O_TIMEOUT = r.tmo;
  assign O_READY = (r.st != lcd_pkg::LCD_POR);

  // Checks on the registered state, one clock domain
  chk_code_step: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && en_q && step_rise && r.code < `LCD_CODE_MAX
    |=> r.code == $past(r.code) + 5'h1)
    else $error("code did not step");

  chk_code_once: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && en_q
    |=> r.code == $past(r.code) || r.code == $past(r.code) + 5'h1)
    else $error("code moved by more than one");

  chk_code_sat: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && r.code == `LCD_CODE_MAX && en_q
    |=> r.code == `LCD_CODE_MAX)
    else $error("code wrapped");

  chk_code_hold: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && en_q && !step_rise
    |=> r.code == $past(r.code))
    else $error("code changed without a rising edge");

  chk_off_clear: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_OFF
    |=> r.code == '0 && !r.drive)
    else $error("code not cleared when disabled");

  chk_en_drop: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    !en_q && O_READY
    |=> !O_DRIVE)
    else $error("driving while disabled");

  chk_drive_on: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_DRIVE
    |-> r.st == lcd_pkg::LCD_ON)
    else $error("driving outside the on state");

  chk_off_wake: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_OFF && en_q
    |=> r.st == lcd_pkg::LCD_ON)
    else $error("enable did not start the driver");

  chk_low_sleep: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_ON && en_q && !step_q && r.low_cnt == 32'(SLEEP_CYC - 1)
    |=> O_SLEEP)
    else $error("no sleep after long low");

  chk_sleep_off: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_SLEEP
    |-> !O_DRIVE)
    else $error("driving while asleep");

  chk_sleep_keep: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_SLEEP && en_q && !step_rise
    |=> r.code == $past(r.code))
    else $error("code lost in sleep");

  chk_tmo_set: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_ON && en_q && r.code > `LCD_CODE_HI &&
    r.tmo_cnt >= 32'(TMO_CYC - 1) |=> O_TIMEOUT && O_SLEEP)
    else $error("high current did not time out");

  chk_tmo_low: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.code <= `LCD_CODE_HI
    |=> r.tmo_cnt == $past(r.tmo_cnt) || r.tmo_cnt == '0)
    else $error("timeout counted at low current");

  chk_tmo_dark: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_TIMEOUT
    |-> !O_DRIVE)
    else $error("driving after timeout");

  chk_tmo_hold: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && r.tmo && en_q
    |=> r.tmo && !r.drive)
    else $error("timeout cleared without enable cycle");

  chk_tmo_clear: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_OFF
    |=> !O_TIMEOUT)
    else $error("timeout kept over enable cycle");

  chk_wake_drive: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_SLEEP && en_q && step_q && !r.tmo && !hot_q
    |=> O_DRIVE)
    else $error("step did not wake the driver");

  chk_settle_reset: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && en_q && step_rise && r.code < `LCD_CODE_MAX
    |=> !O_SETTLED)
    else $error("settled right after a step");

  chk_hot_sleep: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    hot_q && O_READY
    |=> !O_DRIVE)
    else $error("driving while hot");

  chk_hot_keep: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    hot_q && lcd_live(r.st) && en_q && !step_rise
    |=> O_CODE == $past(O_CODE))
    else $error("code lost on thermal trip");

  chk_hot_resume: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    lcd_live(r.st) && en_q && !hot_q && !r.tmo && r.code <= `LCD_CODE_HI &&
    r.low_cnt < 32'(SLEEP_CYC - 1) |=> O_DRIVE)
    else $error("driver did not resume when cool");

  chk_por_ignore: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_POR
    |-> r.code == '0 && !O_DRIVE)
    else $error("step counted during power-on");

  chk_por_len: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    r.st == lcd_pkg::LCD_POR
    |-> r.por_cnt < 32'(POR_CYC))
    else $error("power-on interval too long");

  chk_ready_keep: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    O_READY
    |=> O_READY)
    else $error("ready dropped without reset");

  chk_low_reset: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    step_q && lcd_live(r.st)
    |=> r.low_cnt == '0)
    else $error("low timer not restarted by high step");

  // Main scenarios
  cov_sat: cover property (@(posedge I_REF_CLK)
    r.code == `LCD_CODE_MAX);
  cov_wake: cover property (@(posedge I_REF_CLK)
    O_SLEEP ##1 step_rise ##[1:4] O_DRIVE);
  cov_tmo: cover property (@(posedge I_REF_CLK)
    $rose(r.tmo));
  cov_hot: cover property (@(posedge I_REF_CLK)
    hot_rise ##[1:8] O_SLEEP);
  cov_en: cover property (@(posedge I_REF_CLK)
    en_rise);
endmodule : lcd_ctrl

// ### core/lcd_map.svh
// Constants for the LED current-step control block.
// Assumes a 25 MHz reference clock and a single clock domain.
// Notes on behaviour
// - Each accepted pulse raises code by one
// - Five-bit code, zero gives no current
// - Saturate at 31, ignore further pulses
// - Count rising edges only, any power-up level
// - Lower current only through enable cycling
// - Enable low disables driver, clears code
// - Step input low over 100 us sleeps
// - Sleep zeroes current, keeps code alive
// - Code above 8 times out after 4 s
// - Timeout cleared only by enable cycling
// - Pulses in sleep wake and add up
// - Pulses counted up to 4 MHz
// - Code immediate, output settles after 50 us
// - Over-temperature trip sleeps, keeps code
// - Resume after 25 degree temperature drop
// - Power-up clears code and timeout counter
// - Pulses ignored during power-on reset
// - Power-on reset lasts at most 20 ms
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
`define LCD_CLK_MHZ 25
`define LCD_CODE_W 5
`define LCD_CODE_MAX 5'h1f
`define LCD_CODE_HI 5'h08
`define LCD_SLEEP_US 100
`define LCD_SLEEP_CYC (`LCD_SLEEP_US * `LCD_CLK_MHZ + 1)
`define LCD_SETTLE_US 50
`define LCD_SETTLE_CYC (`LCD_SETTLE_US * `LCD_CLK_MHZ)
`define LCD_TMO_S 4
`define LCD_TMO_CYC (`LCD_TMO_S * 1000000 * `LCD_CLK_MHZ)
`define LCD_POR_MS 20
`define LCD_POR_CYC (`LCD_POR_MS * 1000 * `LCD_CLK_MHZ)
`endif

// ### core/lcd_pkg.sv
// Types for the LED current-step control block.
// Assumes lcd_map.svh is compiled alongside.
package lcd_pkg;
  typedef enum logic [1:0] {
    LCD_POR = 2'b00,
    LCD_OFF = 2'b01,
    LCD_ON = 2'b11,
    LCD_SLEEP = 2'b10
  } lcd_state_t;
endpackage : lcd_pkg

// ### core/lcd_sync.sv
// Two-flop synchroniser with rising-edge detect on the second stage.
// Assumes the input is asynchronous to I_REF_CLK domain.
`timescale 1ns/1ps
module lcd_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q,
  output logic o_rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic warm1;
    logic warm2;
    logic armed;
  } lcd_sync_t;
  lcd_sync_t r;
  lcd_sync_t next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = i_d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Armed only once both compare stages hold real samples
    next_r.warm1 = 1'b1;
    next_r.warm2 = r.warm1;
    next_r.armed = r.warm2;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign o_q = r.s2;
  // No edge on the first sampled level after reset
  assign o_rise = r.armed & r.s2 & ~r.s3;
endmodule : lcd_sync

// ### sim/lcd_host.sv
// Host model driving the enable and step pins.
// Assumes a free clock; pins change 1 ns after a rising edge.
`timescale 1ns/1ps
module lcd_host (
  input wire logic i_clk,
  output logic o_en,
  output logic o_step
);
  initial begin
    o_en = 1'b0;
    o_step = 1'b0;
  end
  task automatic set_en(input logic v);
    @(posedge i_clk) #1 o_en = v;
  endtask : set_en
  task automatic set_step(input logic v);
    @(posedge i_clk) #1 o_step = v;
  endtask : set_step
  // Three high, four low: under the rate ceiling
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge i_clk) #1 o_step = 1'b1;
      repeat (3) @(posedge i_clk);
      #1 o_step = 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask : pulse
endmodule : lcd_host

// ### sim/lcd_ctrl_tb.sv
// Self-checking bench for the LED current-step controller.
// Assumes lcd_host as the host; reset and timeout counts shortened.
`timescale 1ns/1ps
`include "lcd_map.svh"
module lcd_ctrl_tb;
  localparam int POR = 16;
  localparam int TMO = 64;
  localparam int SLEEP = `LCD_SLEEP_CYC;
  localparam int SETTLE = `LCD_SETTLE_CYC;
  logic clk, rst, hot, en, step, drive, settled, slp, tmo, ready;
  logic [`LCD_CODE_W-1:0] code;
  logic [`LCD_CODE_W-1:0] exp_code = '0;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  lcd_host host (.i_clk(clk), .o_en(en), .o_step(step));
  lcd_ctrl #(.POR_CYC(POR), .TMO_CYC(TMO)) dut (
    .I_REF_CLK(clk), .I_RESET(rst), .I_EN(en), .I_STEP(step),
    .I_HOT(hot), .O_CODE(code), .O_DRIVE(drive), .O_SETTLED(settled),
    .O_SLEEP(slp), .O_TIMEOUT(tmo), .O_READY(ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp_code(input logic [`LCD_CODE_W-1:0] got,
      input logic [`LCD_CODE_W-1:0] want);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_code
  task automatic cmp_flag(input logic got, input logic want);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_flag
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wait_cyc
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Pulses on the step pin, tracking the saturating code
  task automatic send(input int n);
    host.pulse(n);
    repeat (n) begin
      if (exp_code != `LCD_CODE_MAX) begin
        exp_code = exp_code + 5'h1;
      end
    end
    wait_cyc(4);
  endtask : send
  task automatic cycle_en();
    host.set_en(1'b0);
    wait_cyc(6);
    exp_code = '0;
    cmp_code(code, exp_code);
    cmp_flag(drive, 1'b0);
    host.set_en(1'b1);
    wait_cyc(6);
  endtask : cycle_en
  task automatic t_por();
    host.pulse(1);
    cmp_flag(ready, 1'b0);
    wait_cyc(POR + 6);
    cmp_flag(ready, 1'b1);
    cmp_code(code, exp_code);
  endtask : t_por
  task automatic t_step();
    send(3);
    cmp_code(code, exp_code);
    cmp_flag(drive, 1'b1);
    cmp_flag(settled, 1'b0);
    wait_cyc(SETTLE);
    cmp_flag(settled, 1'b1);
  endtask : t_step
  task automatic t_sat();
    send(30);
    cmp_code(code, exp_code);
    send(1);
    cmp_code(code, exp_code);
  endtask : t_sat
  task automatic t_off();
    cycle_en();
    cmp_code(code, exp_code);
    send(2);
    cmp_code(code, exp_code);
    cmp_flag(drive, 1'b1);
  endtask : t_off
  task automatic t_sleep();
    send(2);
    wait_cyc(SLEEP - 100);
    cmp_flag(slp, 1'b0);
    wait_cyc(200);
    cmp_flag(slp, 1'b1);
    cmp_flag(drive, 1'b0);
    cmp_code(code, exp_code);
    send(1);
    cmp_code(code, exp_code);
    cmp_flag(drive, 1'b1);
  endtask : t_sleep
  task automatic t_tmo();
    send(4);
    cmp_flag(tmo, 1'b0);
    wait_cyc(TMO + 8);
    cmp_flag(tmo, 1'b1);
    cmp_flag(drive, 1'b0);
    cmp_flag(slp, 1'b1);
    cycle_en();
    cmp_flag(tmo, 1'b0);
    send(8);
    wait_cyc(TMO + 8);
    cmp_flag(tmo, 1'b0);
    cmp_flag(drive, 1'b1);
  endtask : t_tmo
  task automatic t_hot();
    cycle_en();
    send(1);
    @(posedge clk) #1 hot = 1'b1;
    wait_cyc(6);
    cmp_flag(drive, 1'b0);
    cmp_flag(slp, 1'b1);
    cmp_code(code, exp_code);
    @(posedge clk) #1 hot = 1'b0;
    wait_cyc(6);
    cmp_flag(drive, 1'b1);
    cmp_code(code, exp_code);
  endtask : t_hot
  // Mid-run reset with the step pin held high across release
  task automatic t_rst();
    host.set_step(1'b1);
    @(posedge clk) #1 rst = 1'b1;
    wait_cyc(2);
    exp_code = '0;
    cmp_code(code, exp_code);
    cmp_flag(ready, 1'b0);
    cmp_flag(drive, 1'b0);
    cmp_flag(tmo, 1'b0);
    @(posedge clk) #1 rst = 1'b0;
    wait_cyc(POR + 6);
    cmp_flag(ready, 1'b1);
    cmp_code(code, exp_code);
    host.set_step(1'b0);
    wait_cyc(4);
    cmp_code(code, exp_code);
    send(1);
    cmp_code(code, exp_code);
  endtask : t_rst
  initial begin
    rst = 1'b1;
    hot = 1'b0;
    repeat (12) @(posedge clk);
    #2 cmp_code(code, exp_code);
    host.set_en(1'b1);
    rst = 1'b0;
    t_por();
    t_step();
    t_sat();
    t_off();
    t_sleep();
    t_tmo();
    t_hot();
    t_rst();
    report_and_stop();
  end
endmodule : lcd_ctrl_tb
